// File: core/hsp_defines.vh
// Purpose: shared constants of the hub strap and port configuration block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef HSP_DEFINES_VH
`define HSP_DEFINES_VH

`define HSP_NUM_PORTS        7
`define HSP_ADDR_W           12

// register byte offsets
`define HSP_OFS_CTRL         12'h000
`define HSP_OFS_LED          12'h004
`define HSP_OFS_POWER        12'h008
`define HSP_OFS_STATUS       12'h00c
`define HSP_OFS_RAW          12'h010

// control register fields
`define HSP_CTRL_DIS_EN      0
`define HSP_CTRL_SWP_EN      1
`define HSP_CTRL_GANG_EN     2
`define HSP_CTRL_CONNECT     3
`define HSP_CTRL_LED_EN      4
`define HSP_CTRL_W           5
`define HSP_CTRL_RESET       5'h0f

// indicator register fields
`define HSP_LED_PRI_LSB      0
`define HSP_LED_PRI_MSB      6
`define HSP_LED_ENH_LSB      8
`define HSP_LED_ENH_MSB      12
`define HSP_LED_RESET        13'h0000

// power register field
`define HSP_PWR_LSB          0
`define HSP_PWR_MSB          6
`define HSP_PWR_RESET        7'h00

// status and raw strap fields
`define HSP_ST_DIS_LSB       0
`define HSP_ST_DIS_MSB       6
`define HSP_ST_SWP_LSB       8
`define HSP_ST_SWP_MSB       14
`define HSP_ST_GANG          16
`define HSP_ST_SENSE         17
`define HSP_ST_PULLUP        18
`define HSP_ST_SAMPLED       19

`endif

// File: core/hsp_strap_latch.v
// Purpose: capture a strap vector once, at the first edge after reset release
// Assumes: strap pins are stable and undriven by the chip around release
// Notes:   value stays frozen until the next reset
module hsp_strap_latch #(
  parameter WIDTH = 15
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] strap_pins,
  output reg  [WIDTH-1:0] strap_value,
  output reg              strap_done
);

  // async reset loads a constant; the pins are taken by the clock after release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_value <= {WIDTH{1'b0}};
      strap_done  <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_value <= strap_pins;
      strap_done  <= 1'b1;
    end
  end

endmodule

// File: core/hsp_top.v
// Purpose: reset-time strap capture and per-port pin functions of a seven-port hub
// Assumes: strap and sense inputs are synchronous to pclk; APB slave at 250 MHz
// Notes:   shared pins are released for straps until capture is done
//          option enables act at use, so clearing one drops a captured strap at once
//          straps are taken once; a board change is seen only after a new reset
// Function
// - upstream pull-up follows the upstream supply sense input
// - port disable strap sampled at reset release; high marks port disabled
// - sampled strap used only while its strap option is enabled
// - port power enables are active high
// - primary indicators driven when indicator support is enabled
// - polarity swap strap sampled at reset release, sets port data polarity
// - swap 0 normal, indicator active high; swap 1 swapped, active low
// - enhanced indicators of ports four to seven are active low
// - enhanced port three indicator active high unless ganged strap makes it active low
// - ganged strap selects common or per-port power control
// - ganged strap sampled at reset release when its option is enabled
// - ganged 0 individual, port three active high; 1 ganged, active low
//
// Register access over APB and the placing of the registers are this design's own decisions.
`include "hsp_defines.vh"

module hsp_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        upstream_supply_sense,
  output reg         upstream_pullup_enable,
  input  wire [6:0]  port_disable_strap_plus,
  input  wire [6:0]  port_disable_strap_minus,
  output reg  [6:0]  downstream_port_enable,
  output reg  [6:0]  downstream_polarity_swap,
  output reg  [6:0]  port_power_enable,
  output reg         gang_mode,
  input  wire [6:0]  port_polarity_swap_strap,
  output reg  [6:0]  primary_port_indicator,
  output reg  [6:0]  primary_port_indicator_oe,
  output reg  [3:0]  enhanced_port_indicator,
  output reg  [3:0]  enhanced_port_indicator_oe,
  input  wire        enhanced_port3_strap,
  output reg         enhanced_port3_indicator,
  output reg         enhanced_port3_indicator_oe
);

  // pin level for an indicator: on state xor active-low polarity
  function [6:0] led_level;
    input [6:0] on;
    input [6:0] active_low;
    begin
      led_level = on ^ active_low;
    end
  endfunction

  // word decode shared by read and write paths
  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr[11:2] == offset[11:2]);
    end
  endfunction

  // status and raw words share one layout for bits 0 to 16; status adds sense, pull-up and sampled bits 17 to 19
  function [31:0] strap_word;
    input [6:0] dis;
    input [6:0] swp;
    input       gang;
    begin
      strap_word                                   = 32'h0000_0000;
      strap_word[`HSP_ST_DIS_MSB:`HSP_ST_DIS_LSB] = dis;
      strap_word[`HSP_ST_SWP_MSB:`HSP_ST_SWP_LSB] = swp;
      strap_word[`HSP_ST_GANG]                    = gang;
    end
  endfunction

  reg  [`HSP_CTRL_W-1:0] ctrl;
  reg  [12:0]            led_cfg;
  reg  [6:0]             power_req;

  wire [14:0]            strap_pins;
  wire [14:0]            strap_value;
  wire                   strap_done;

  wire [6:0]             raw_disable;
  wire [6:0]             raw_swap;
  wire                   raw_gang;
  wire [6:0]             eff_disable;
  wire [6:0]             eff_swap;
  wire                   eff_gang;
  wire                   led_en;

  wire                   apb_setup;
  wire                   apb_access;
  wire                   apb_write;
  wire                   hit_ctrl;
  wire                   hit_led;
  wire                   hit_power;
  wire                   hit_status;
  wire                   hit_raw;
  wire                   hit_any;

  reg  [31:0]            next_prdata;
  reg  [6:0]             next_power;
  reg  [6:0]             next_primary;
  reg  [3:0]             next_enhanced;
  reg                    next_enh3;
  reg                    next_pullup;
  reg  [6:0]             next_port_en;
  reg                    next_led_oe;

  // disable strap: a pulled-up pin on either line of the pair marks the port
  // strap pins: port three gang, polarity swap and disable straps
  assign strap_pins = {enhanced_port3_strap,
                       port_polarity_swap_strap,
                       port_disable_strap_plus | port_disable_strap_minus};

  hsp_strap_latch #(
    .WIDTH       (15)
  ) u_strap_latch (
    .pclk        (pclk),
    .presetn     (presetn),
    .strap_pins  (strap_pins),
    .strap_value (strap_value),
    .strap_done  (strap_done)
  );

  assign raw_disable = strap_value[6:0];
  assign raw_swap    = strap_value[13:7];
  assign raw_gang    = strap_value[14];

  // enable is applied at use, so a cleared option ignores the sampled pin
  // option gating
  assign eff_disable = raw_disable & {7{ctrl[`HSP_CTRL_DIS_EN]}};
  assign eff_swap    = raw_swap & {7{ctrl[`HSP_CTRL_SWP_EN]}};
  assign eff_gang    = raw_gang & ctrl[`HSP_CTRL_GANG_EN];
  assign led_en      = ctrl[`HSP_CTRL_LED_EN];

  assign apb_setup   = psel & ~penable;
  assign apb_access  = psel & penable & ~pready;
  assign apb_write   = psel & penable & pready & pwrite;

  assign hit_ctrl    = addr_hit(paddr, `HSP_OFS_CTRL);
  assign hit_led     = addr_hit(paddr, `HSP_OFS_LED);
  assign hit_power   = addr_hit(paddr, `HSP_OFS_POWER);
  assign hit_status  = addr_hit(paddr, `HSP_OFS_STATUS);
  assign hit_raw     = addr_hit(paddr, `HSP_OFS_RAW);
  assign hit_any     = hit_ctrl | hit_led | hit_power | hit_status | hit_raw;

  // read mux, registered during the first access cycle
  always @*
  begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl)
    begin
      next_prdata[`HSP_CTRL_W-1:0] = ctrl;
    end
    else if (hit_led)
    begin
      next_prdata[12:0] = led_cfg;
    end
    else if (hit_power)
    begin
      next_prdata[`HSP_PWR_MSB:`HSP_PWR_LSB] = power_req;
    end
    else if (hit_status)
    begin
      next_prdata                  = strap_word(eff_disable, eff_swap, eff_gang);
      next_prdata[`HSP_ST_SENSE]   = upstream_supply_sense;
      next_prdata[`HSP_ST_PULLUP]  = upstream_pullup_enable;
      next_prdata[`HSP_ST_SAMPLED] = strap_done;
    end
    else if (hit_raw)
    begin
      next_prdata = strap_word(raw_disable, raw_swap, raw_gang);
    end
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_access;
      // an unmapped word answers with an error instead of hanging the master
      pslverr <= apb_access & ~hit_any;
    end
  end

  // read data stands from the answer until the next setup clears it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (apb_access)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
    else if (apb_setup)
    begin
      prdata <= 32'h0000_0000;
    end
  end

  // writes land only at the completing edge; read-only words ignore writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl      <= `HSP_CTRL_RESET;
      led_cfg   <= `HSP_LED_RESET;
      power_req <= `HSP_PWR_RESET;
    end
    else if (apb_write)
    begin
      if (hit_ctrl)
      begin
        ctrl <= pwdata[`HSP_CTRL_W-1:0];
      end
      if (hit_led)
      begin
        led_cfg <= pwdata[12:0];
      end
      if (hit_power)
      begin
        power_req <= pwdata[`HSP_PWR_MSB:`HSP_PWR_LSB];
      end
    end
  end

  // port power: ganged ports all follow port one's request
  always @*
  begin
    if (eff_gang)
    begin
      next_power = {7{power_req[0]}};
    end
    else
    begin
      next_power = power_req;
    end
    next_power = next_power & ~eff_disable & {7{strap_done}};
  end

  // indicator levels per polarity set by the straps; ports four to seven fixed active low
  always @*
  begin
    next_primary  = led_level(led_cfg[`HSP_LED_PRI_MSB:`HSP_LED_PRI_LSB], eff_swap);
    // ports four to seven active low
    next_enhanced = ~led_cfg[`HSP_LED_ENH_MSB:`HSP_LED_ENH_LSB+1];
    // port three polarity from gang strap
    next_enh3     = led_cfg[`HSP_LED_ENH_LSB] ^ eff_gang;
    // connect only with upstream supply present
    next_pullup   = upstream_supply_sense & ctrl[`HSP_CTRL_CONNECT] & strap_done;
  end

  // nothing is usable or driven before the straps have been taken
  always @*
  begin
    next_port_en = ~eff_disable & {7{strap_done}};
    next_led_oe  = led_en & strap_done;
  end

  // port-side outputs; power and enables stay off while straps are being captured
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upstream_pullup_enable   <= 1'b0;
      downstream_port_enable   <= 7'h00;
      downstream_polarity_swap <= 7'h00;
      port_power_enable        <= 7'h00;
      gang_mode                <= 1'b0;
    end
    else
    begin
      upstream_pullup_enable   <= next_pullup;
      downstream_port_enable   <= next_port_en;
      downstream_polarity_swap <= eff_swap;
      port_power_enable        <= next_power;
      gang_mode                <= eff_gang;
    end
  end

  // indicator levels follow the on bits at the polarity the straps chose, fixed active low for ports four to seven
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_port_indicator   <= 7'h00;
      enhanced_port_indicator  <= 4'h0;
      enhanced_port3_indicator <= 1'b0;
    end
    else
    begin
      primary_port_indicator   <= next_primary;
      enhanced_port_indicator  <= next_enhanced;
      enhanced_port3_indicator <= next_enh3;
    end
  end

  // shared pins stay released until capture, so the board resistors set the straps
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_port_indicator_oe   <= 7'h00;
      enhanced_port_indicator_oe  <= 4'h0;
      enhanced_port3_indicator_oe <= 1'b0;
    end
    else
    begin
      primary_port_indicator_oe   <= {7{next_led_oe}};
      enhanced_port_indicator_oe  <= {4{next_led_oe}};
      enhanced_port3_indicator_oe <= next_led_oe;
    end
  end

endmodule

// File: verif/hsp_board.sv
// Purpose: board strap resistors behind the shared indicator pins
// Assumes: chip drive overrides the resistor whenever its enable is high
// Notes:   disable straps are driven by the bench directly
module hsp_board (
  input  logic [6:0] swap_res,
  input  logic       gang_res,
  input  logic [6:0] led_lvl,
  input  logic [6:0] led_oe,
  input  logic       b3_lvl,
  input  logic       b3_oe,
  output logic [6:0] swap_pin,
  output logic       gang_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign swap_pin = (led_oe & led_lvl) | (~led_oe & swap_res);
  assign gang_pin = b3_oe ? b3_lvl : gang_res;
endmodule

// File: verif/hsp_top_assertions.sv
// Purpose: port-level checks of the strap block
// Assumes: one clock, async active-low reset
// Notes:   watches a subset of the top ports
module hsp_chk (
  input logic       pclk,
  input logic       presetn,
  input logic       pready,
  input logic       pslverr,
  input logic       upstream_supply_sense,
  input logic       upstream_pullup_enable,
  input logic [6:0] port_power_enable,
  input logic [6:0] downstream_port_enable,
  input logic       gang_mode,
  input logic [6:0] primary_port_indicator_oe,
  input logic [3:0] enhanced_port_indicator_oe,
  input logic       enhanced_port3_indicator_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pullup_sense: assert property (
    upstream_pullup_enable |-> $past(upstream_supply_sense)) else $error("pullup without sense");
  chk_pins_released: assert property (
    !$past(presetn) |-> primary_port_indicator_oe == 7'h00 && !enhanced_port3_indicator_oe)
    else $error("pin driven before capture");
  chk_pri_oe_all: assert property (
    primary_port_indicator_oe == 7'h00 || primary_port_indicator_oe == 7'h7f)
    else $error("primary enables split");
  chk_enh_oe_all: assert property (
    enhanced_port_indicator_oe == {4{primary_port_indicator_oe[0]}})
    else $error("enhanced enables split");
  chk_enh3_oe: assert property (
    enhanced_port3_indicator_oe == primary_port_indicator_oe[0]) else $error("port3 enable");
  chk_disabled_unpowered: assert property (
    (port_power_enable & ~downstream_port_enable) == 7'h00) else $error("disabled port powered");
  chk_gang_power: assert property (
    gang_mode && $past(gang_mode) |->
    port_power_enable == 7'h00 || port_power_enable == downstream_port_enable)
    else $error("ganged ports differ");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  cover property (gang_mode);
  cover property (upstream_pullup_enable);
  cover property (pslverr);
endmodule

bind hsp_top hsp_chk u_chk (.*);

// File: verif/hsp_strap_test.sv
// Purpose: directed bench of the strap block
// Assumes: apb answers within a few cycles
// Notes:   straps are set at each reset; t_straps later changes a disable strap to check it is not retaken
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module hsp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, upstream_supply_sense = 1, upstream_pullup_enable;
  logic [6:0]  port_disable_strap_plus = 0, port_disable_strap_minus = 0, sw_res = 0;
  logic [6:0]  downstream_port_enable, downstream_polarity_swap, port_power_enable;
  logic [6:0]  port_polarity_swap_strap, primary_port_indicator, primary_port_indicator_oe;
  logic [3:0]  enhanced_port_indicator, enhanced_port_indicator_oe;
  logic        gang_mode, enhanced_port3_strap, enhanced_port3_indicator;
  logic        enhanced_port3_indicator_oe, g_res = 0;
  int          err_count = 0, comparisons = 0, cycles = 0;

  hsp_board brd (.swap_res(sw_res), .gang_res(g_res), .led_lvl(primary_port_indicator),
    .led_oe(primary_port_indicator_oe), .b3_lvl(enhanced_port3_indicator),
    .b3_oe(enhanced_port3_indicator_oe), .swap_pin(port_polarity_swap_strap),
    .gang_pin(enhanced_port3_strap));
  hsp_top dut (.*);

  always #2 pclk = ~pclk;
  // bench needs well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      complete_run;
    end
  end

  task complete_run;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task rst(input logic [6:0] dp, input logic [6:0] dm, input logic [6:0] sw, input logic g);
    @(posedge pclk);
    presetn <= 0;
    port_disable_strap_plus <= dp;
    port_disable_strap_minus <= dm;
    sw_res <= sw;
    g_res <= g;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    settle;
  endtask

  task t_straps;
    rst(7'h05, 7'h40, 7'h2a, 1'b0);
    `CHK(downstream_port_enable, 7'h3a)
    `CHK(downstream_polarity_swap, 7'h2a)
    `CHK(primary_port_indicator_oe, 7'h00)
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000000f)
    apb(0, 12'h00c, 0);
    `CHK(rd, 32'h000e2a45)
    apb(1, 12'h000, 32'h1f);
    apb(1, 12'h004, 32'h150f);
    apb(1, 12'h008, 32'h7f);
    settle;
    `CHK(primary_port_indicator, 7'h25)
    `CHK(primary_port_indicator_oe, 7'h7f)
    `CHK(enhanced_port_indicator_oe, 4'hf)
    `CHK(enhanced_port_indicator, 4'h5)
    `CHK(enhanced_port3_indicator, 1'b1)
    `CHK(port_power_enable, 7'h3a)
    @(posedge pclk);
    port_disable_strap_plus <= 7'h00;
    settle;
    `CHK(downstream_port_enable, 7'h3a)
    apb(1, 12'h010, 32'h0);
    apb(0, 12'h010, 0);
    `CHK(rd, 32'h00002a45)
    apb(0, 12'h020, 0);
    `CHK({er, rd}, 33'h100000000)
    $display("test straps done");
  endtask

  task t_opts;
    apb(1, 12'h000, 32'h18);
    settle;
    `CHK(downstream_port_enable, 7'h7f)
    `CHK(downstream_polarity_swap, 7'h00)
    `CHK(primary_port_indicator, 7'h0f)
    `CHK(port_power_enable, 7'h7f)
    $display("test options done");
  endtask

  task t_pullup;
    @(posedge pclk);
    upstream_supply_sense <= 0;
    settle;
    `CHK(upstream_pullup_enable, 1'b0)
    @(posedge pclk);
    upstream_supply_sense <= 1;
    settle;
    `CHK(upstream_pullup_enable, 1'b1)
    apb(1, 12'h000, 32'h10);
    settle;
    `CHK(upstream_pullup_enable, 1'b0)
    $display("test pullup done");
  endtask

  task t_gang;
    rst(7'h00, 7'h02, 7'h00, 1'b1);
    `CHK(gang_mode, 1'b1)
    apb(1, 12'h000, 32'h1f);
    apb(1, 12'h004, 32'h100);
    apb(1, 12'h008, 32'h01);
    settle;
    `CHK(port_power_enable, 7'h7d)
    `CHK(enhanced_port3_indicator, 1'b0)
    `CHK(enhanced_port3_indicator_oe, 1'b1)
    apb(1, 12'h008, 32'h7e);
    settle;
    `CHK(port_power_enable, 7'h00)
    apb(1, 12'h000, 32'h1b);
    settle;
    `CHK(gang_mode, 1'b0)
    `CHK(port_power_enable, 7'h7c)
    $display("test gang done");
  endtask

  initial
  begin
    t_straps;
    t_opts;
    t_pullup;
    t_gang;
    complete_run;
  end
endmodule
